// ### include/irq_cfg.svh
// offsets, field positions, reset values and counts of the interrupt handler
// assumes inclusion by bare name from the package and the top module
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH
`define IRQ_NSRC 13
`define IRQ_CALL_CYCLES 4
`define IRQ_VEC_BASE 16'h0003
`define IRQ_VEC_STEP 16'h0008
`define IRQ_GAP0 4'h8
`define IRQ_GAP1 4'hC
`define IRQ_EXT0_SRC 4'h0
`define IRQ_EXT1_SRC 4'h2
`define IRQ_EXT_MASK 13'h0005
`define REG_ENABLE 8'h00
`define REG_PRIORITY 8'h04
`define REG_PEND_SET 8'h08
`define REG_PEND_CLR 8'h0C
`define REG_EXT_CFG 8'h10
`define REG_STATUS 8'h14
`define EN_GLOBAL_BIT 16
`define RST_ENABLE 13'h0000
`define RST_PRIORITY 13'h0000
`define RST_EXT_CFG 4'h0
`endif

// ### include/irq_pkg.sv
// types shared by the interrupt handler modules
// assumes irq_cfg.svh on the include path
`include "irq_cfg.svh"
package irq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } call_state_t;
  typedef struct packed {
    logic [1:0] pol;
    logic [1:0] edge_sel;
  } ext_cfg_t;
  typedef struct packed {
    logic hi;
    logic lo;
  } in_service_t;
endpackage

// ### verification/core_model.sv
// behavioural cpu sequencer facing the interrupt handler
// assumes the bench drives return_from_interrupt_cmd and gap by non-blocking assignment after CLK
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // from handler and bench
  input wire logic call_active,
  input wire logic return_from_interrupt_cmd,
  input wire logic [3:0] gap,
  // instruction ends
  output logic insn_end,
  output logic return_from_interrupt_end
);
  // ----------------------------------------
  // instruction slots
  // ----------------------------------------
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic slot;

  // no instruction ends while the forced call runs; gap of one or more
  // keeps every instruction after a global disable a multi cycle one
  always_comb begin
    slot = (cnt_q >= gap) && !call_active;
    cnt_d = (call_active || slot) ? 4'h0 : cnt_q + 4'h1;
    insn_end = slot && !return_from_interrupt_cmd;
    return_from_interrupt_end = slot && return_from_interrupt_cmd;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // core_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the two level interrupt handler
// assumes irq_pkg compiled first and irq_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "irq_cfg.svh"
module tb_top import irq_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic CLK, RSTN, READ, WRITE, EXT_IRQ0, EXT_IRQ1, return_from_interrupt_cmd;
  logic WAITREQUEST, IRQ_REQ, CALL_ACTIVE, IN_SERVICE_HI, IN_SERVICE_LO, INSN_END, RETURN_FROM_INTERRUPT_END;
  logic [7:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA, rd;
  logic [12:0] EVENT;
  logic [15:0] CALL_VECTOR;
  logic [3:0] gap, BYTEENABLE;
  int err_count, checks_done, i;

  irq_handler i_dut (.CLK, .RSTN, .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
    .WAITREQUEST, .EVENT, .EXT_IRQ0, .EXT_IRQ1, .INSN_END, .RETURN_FROM_INTERRUPT_END, .IRQ_REQ, .CALL_ACTIVE,
    .CALL_VECTOR, .IN_SERVICE_HI, .IN_SERVICE_LO);
  core_model i_core (.clk(CLK), .rstn(RSTN), .call_active(CALL_ACTIVE), .return_from_interrupt_cmd(return_from_interrupt_cmd), .gap(gap),
    .insn_end(INSN_END), .return_from_interrupt_end(RETURN_FROM_INTERRUPT_END));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one wait state expected, but the wait is open ended up to a bound
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    ADDRESS <= a;
    WRITE <= wr;
    READ <= !wr;
    WRITEDATA <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    rd = READDATA;
    if (n >= 50) err_count++;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge CLK);
      if ((IRQ_REQ | CALL_ACTIVE) !== 1'b0) k++;
    end
    chk(32'(k), 32'h0);
  endtask

  // counts instruction ends up to entry, then the call length
  task automatic wait_call(input logic [15:0] vec, input int ins, input logic [1:0] mk);
    int n, k, len;
    n = 0;
    k = 0;
    len = 0;
    while (CALL_ACTIVE !== 1'b1 && n < 200) begin
      @(posedge CLK);
      n++;
      if (INSN_END === 1'b1) k++;
    end
    do begin
      @(posedge CLK);
      len++;
    end while (CALL_ACTIVE === 1'b1 && len < 20);
    chk(32'(CALL_VECTOR), 32'(vec));
    chk(32'(len), 32'h4);
    chk(32'({IN_SERVICE_HI, IN_SERVICE_LO}), 32'(mk));
    if (ins >= 0) chk(32'(k), 32'(ins));
  endtask

  task automatic return_from_interrupt();
    int n;
    n = 0;
    return_from_interrupt_cmd <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (RETURN_FROM_INTERRUPT_END !== 1'b1 && n < 50);
    return_from_interrupt_cmd <= 1'b0;
    if (n >= 50) err_count++;
  endtask

  // reserved vector slots sit after index 7 and after index 11
  function automatic logic [15:0] vec_of(input int s);
    return 16'(3 + 8 * (s + int'(s >= 8) + int'(s >= 12)));
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    RSTN = 1'b0;
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = 8'h00;
    WRITEDATA = 32'h0;
    EVENT = 13'h0000;
    EXT_IRQ0 = 1'b1;
    EXT_IRQ1 = 1'b1;
    return_from_interrupt_cmd = 1'b0;
    gap = 4'h3;
    BYTEENABLE = 4'hF;
    err_count = 0;
    checks_done = 0;
    rd = 32'h0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    rdc(`REG_ENABLE, 32'h0);
    rdc(`REG_PRIORITY, 32'h0);
    rdc(`REG_EXT_CFG, 32'h0);
    rdc(`REG_PEND_CLR, 32'h0);
    rdc(8'h20, 32'h0);
    $display("test reset done");
    EVENT <= 13'h0020;
    @(posedge CLK);
    EVENT <= 13'h0000;
    quiet(6);
    rdc(`REG_PEND_SET, 32'h20);
    wr(`REG_ENABLE, 32'h20);
    quiet(8);
    wr(`REG_ENABLE, 32'h1_0020);
    wait_call(16'h002B, -1, 2'b01);
    rdc(`REG_PEND_SET, 32'h20);
    rdc(`REG_STATUS, 32'h002B_0051);
    return_from_interrupt();
    wait_call(16'h002B, 1, 2'b01);
    wr(`REG_PEND_CLR, 32'h20);
    return_from_interrupt();
    quiet(8);
    chk(32'({IN_SERVICE_HI, IN_SERVICE_LO}), 32'h0);
    $display("test single source done");
    wr(`REG_EXT_CFG, 32'h3);
    wr(`REG_ENABLE, 32'h1_1FFF);
    for (i = 0; i < 13; i++) begin
      wr(`REG_PEND_SET, 32'h1 << i);
      wait_call(vec_of(i), -1, 2'b01);
      wr(`REG_PEND_CLR, 32'h1 << i);
      return_from_interrupt();
    end
    $display("test vectors done");
    wr(`REG_ENABLE, 32'h1_0048);
    wr(`REG_PRIORITY, 32'h40);
    wr(`REG_PEND_SET, 32'h48);
    wait_call(16'h0033, -1, 2'b10);
    quiet(10);
    wr(`REG_PEND_CLR, 32'h40);
    return_from_interrupt();
    wait_call(16'h001B, 1, 2'b01);
    wr(`REG_PEND_SET, 32'h40);
    wait_call(16'h0033, -1, 2'b11);
    wr(`REG_PEND_CLR, 32'h48);
    return_from_interrupt();
    quiet(8);
    chk(32'({IN_SERVICE_HI, IN_SERVICE_LO}), 32'h1);
    return_from_interrupt();
    $display("test priority done");
    wr(`REG_ENABLE, 32'h0);
    EXT_IRQ0 <= 1'b0;
    wr(`REG_EXT_CFG, 32'h4);
    // polarity change reaches the level flag two edges later
    repeat (2) @(posedge CLK);
    rdc(`REG_PEND_SET, 32'h0);
    EXT_IRQ0 <= 1'b1;
    repeat (3) @(posedge CLK);
    rdc(`REG_PEND_SET, 32'h1);
    EXT_IRQ0 <= 1'b0;
    repeat (3) @(posedge CLK);
    rdc(`REG_PEND_SET, 32'h0);
    wr(`REG_EXT_CFG, 32'h6);
    wr(`REG_ENABLE, 32'h1_0004);
    EXT_IRQ1 <= 1'b0;
    wait_call(16'h0013, -1, 2'b01);
    rdc(`REG_PEND_SET, 32'h0);
    return_from_interrupt();
    quiet(8);
    EXT_IRQ1 <= 1'b1;
    wr(`REG_ENABLE, 32'h1_0001);
    EXT_IRQ0 <= 1'b1;
    wait_call(16'h0003, -1, 2'b01);
    EXT_IRQ0 <= 1'b0;
    return_from_interrupt();
    quiet(8);
    $display("test external done");
    BYTEENABLE <= 4'h1;
    wr(`REG_ENABLE, 32'h0000_00F0);
    BYTEENABLE <= 4'hF;
    rdc(`REG_ENABLE, 32'h0001_00F0);
    $display("test byte lanes done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire

// ### verilog/ext_irq_sense.sv
// polarity and edge detection for the two external interrupt inputs
// assumes pins synchronous to clk; pins are only sampled, never driven
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sense import irq_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and configuration
  input wire logic [1:0] pin,
  input wire ext_cfg_t cfg,
  // conditioned outputs
  output logic [1:0] active,
  output logic [1:0] edge_hit
);
  logic [1:0] act_q, act_d, prev_q, prev_d;

  // ----------------------------------------
  // per input sampling
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_in
    always_comb begin
      act_d[i] = pin[i] ~^ cfg.pol[i];
      prev_d[i] = act_q[i];
    end
    assign active[i] = act_q[i];
    assign edge_hit[i] = act_q[i] & ~prev_q[i];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= 2'h0;
      prev_q <= 2'h0;
    end else begin
      act_q <= act_d;
      prev_q <= prev_d;
    end
  end
endmodule // ext_irq_sense
`default_nettype wire

// ### verilog/irq_handler.sv
// two level interrupt handler with Avalon-MM register slave
// assumes core pulses INSN_END and RETURN_FROM_INTERRUPT_END; pins synchronous to CLK
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "irq_cfg.svh"
module irq_handler import irq_pkg::*; #(
  parameter int NSRC = `IRQ_NSRC,
  parameter int CALL_CYCLES = `IRQ_CALL_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register bus
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // peripheral events and external pins
  input wire logic [NSRC-1:0] EVENT,
  input wire logic EXT_IRQ0,
  input wire logic EXT_IRQ1,
  // cpu sequencer
  input wire logic INSN_END,
  input wire logic RETURN_FROM_INTERRUPT_END,
  output logic IRQ_REQ,
  output logic CALL_ACTIVE,
  output logic [15:0] CALL_VECTOR,
  output logic IN_SERVICE_HI,
  output logic IN_SERVICE_LO
);
  localparam int SW = 4;

  logic [NSRC-1:0] en_q, en_d, prio_q, prio_d, pend_q, pend_d;
  logic ea_q, ea_d;
  ext_cfg_t cfg_q, cfg_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wmask, wd;
  logic wr_go;
  logic [1:0] ext_act, ext_edge;
  logic [NSRC-1:0] cand, hi_c, lo_c, set_v, clr_v;
  logic hi_any, lo_any;
  logic [SW-1:0] hi_idx, lo_idx, sel_q, sel_d;
  logic sel_lvl_q, sel_lvl_d, req_q, req_d;
  call_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] vec_q, vec_d;
  in_service_t isr_q, isr_d;
  logic entry;

  // ----------------------------------------
  // vector of a source
  // ----------------------------------------
  // reserved slots in the table are skipped, so index and order differ
  function automatic logic [15:0] vec_of(input logic [SW-1:0] s);
    logic [15:0] o;
    o = {12'h000, s};
    if (s >= `IRQ_GAP0) begin
      o = o + 16'h0001;
    end
    if (s >= `IRQ_GAP1) begin
      o = o + 16'h0001;
    end
    vec_of = `IRQ_VEC_BASE + o * `IRQ_VEC_STEP;
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // one wait state on every access; writes land at the answering edge
  assign wmask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}}, {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
  assign wd = WRITEDATA & wmask;
  assign wr_go = WRITE & ~wait_q;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((READ | WRITE) & wait_q) begin
      wait_d = 1'b0;
      case (ADDRESS)
        `REG_ENABLE: rdata_d = {15'h0000, ea_q, 3'h0, en_q};
        `REG_PRIORITY: rdata_d = {19'h00000, prio_q};
        `REG_PEND_SET: rdata_d = {19'h00000, pend_q};
        `REG_EXT_CFG: rdata_d = {28'h0000000, cfg_q};
        `REG_STATUS: rdata_d = {vec_q, 8'h00, sel_q, st_q == ST_CALL, req_q, isr_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_comb begin
    en_d = en_q;
    ea_d = ea_q;
    prio_d = prio_q;
    cfg_d = cfg_q;
    if (wr_go) begin
      case (ADDRESS)
        `REG_ENABLE: begin
          en_d = (en_q & ~wmask[NSRC-1:0]) | wd[NSRC-1:0];
          ea_d = wmask[`EN_GLOBAL_BIT] ? wd[`EN_GLOBAL_BIT] : ea_q;
        end
        `REG_PRIORITY: prio_d = (prio_q & ~wmask[NSRC-1:0]) | wd[NSRC-1:0];
        `REG_EXT_CFG: cfg_d = (cfg_q & ~wmask[3:0]) | wd[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // external inputs
  // ----------------------------------------
  ext_irq_sense u_sense (
    .clk(CLK),
    .rstn(RSTN),
    .pin({EXT_IRQ1, EXT_IRQ0}),
    .cfg(cfg_q),
    .active(ext_act),
    .edge_hit(ext_edge)
  );

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // set wins over clear, so an event in a clearing cycle survives
  always_comb begin
    set_v = EVENT & ~`IRQ_EXT_MASK;
    set_v[`IRQ_EXT0_SRC] = ext_edge[0] & cfg_q.edge_sel[0];
    set_v[`IRQ_EXT1_SRC] = ext_edge[1] & cfg_q.edge_sel[1];
    clr_v = '0;
    if (wr_go && ADDRESS == `REG_PEND_SET) begin
      set_v = set_v | wd[NSRC-1:0];
    end
    if (wr_go && ADDRESS == `REG_PEND_CLR) begin
      clr_v = wd[NSRC-1:0];
    end
    if (entry && sel_q == `IRQ_EXT0_SRC && cfg_q.edge_sel[0]) begin
      clr_v[`IRQ_EXT0_SRC] = 1'b1;
    end
    if (entry && sel_q == `IRQ_EXT1_SRC && cfg_q.edge_sel[1]) begin
      clr_v[`IRQ_EXT1_SRC] = 1'b1;
    end
    pend_d = (pend_q & ~clr_v) | set_v;
    if (!cfg_q.edge_sel[0]) begin
      pend_d[`IRQ_EXT0_SRC] = ext_act[0];
    end
    if (!cfg_q.edge_sel[1]) begin
      pend_d[`IRQ_EXT1_SRC] = ext_act[1];
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  assign cand = pend_q & en_q & {NSRC{ea_q}};
  assign hi_c = cand & prio_q;
  assign lo_c = cand & ~prio_q;

  irq_pick #(.N(NSRC), .W(SW)) u_pick_hi (
    .req(hi_c),
    .any(hi_any),
    .idx(hi_idx)
  );

  irq_pick #(.N(NSRC), .W(SW)) u_pick_lo (
    .req(lo_c),
    .any(lo_any),
    .idx(lo_idx)
  );

  // decoded each cycle from next marker state, so a return frees the level at once
  always_comb begin
    sel_d = sel_q;
    sel_lvl_d = sel_lvl_q;
    req_d = 1'b0;
    if (st_d == ST_IDLE) begin
      if (hi_any && !isr_d.hi) begin
        req_d = 1'b1;
        sel_d = hi_idx;
        sel_lvl_d = 1'b1;
      end else if (lo_any && !isr_d.hi && !isr_d.lo) begin
        req_d = 1'b1;
        sel_d = lo_idx;
        sel_lvl_d = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // call sequence and service markers
  // ----------------------------------------
  // a request latched before a global disable may still enter on a
  // single cycle instruction; a longer one sees the request withdrawn
  assign entry = st_q == ST_IDLE && req_q && INSN_END;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    vec_d = vec_q;
    isr_d = isr_q;
    if (RETURN_FROM_INTERRUPT_END) begin
      if (isr_q.hi) begin
        isr_d.hi = 1'b0;
      end else begin
        isr_d.lo = 1'b0;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (entry) begin
          st_d = ST_CALL;
          cnt_d = 3'(CALL_CYCLES - 1);
          vec_d = vec_of(sel_q);
          if (sel_lvl_q) begin
            isr_d.hi = 1'b1;
          end else begin
            isr_d.lo = 1'b1;
          end
        end
      end
      ST_CALL: begin
        if (cnt_q == 3'h0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      en_q <= `RST_ENABLE;
      ea_q <= 1'b0;
      prio_q <= `RST_PRIORITY;
      cfg_q <= `RST_EXT_CFG;
      pend_q <= '0;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      sel_q <= '0;
      sel_lvl_q <= 1'b0;
      req_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= 3'h0;
      vec_q <= 16'h0000;
      isr_q <= '0;
    end else begin
      en_q <= en_d;
      ea_q <= ea_d;
      prio_q <= prio_d;
      cfg_q <= cfg_d;
      pend_q <= pend_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      sel_q <= sel_d;
      sel_lvl_q <= sel_lvl_d;
      req_q <= req_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      vec_q <= vec_d;
      isr_q <= isr_d;
    end
  end

  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;
  assign IRQ_REQ = req_q;
  assign CALL_ACTIVE = st_q[1];
  assign CALL_VECTOR = vec_q;
  assign IN_SERVICE_HI = isr_q.hi;
  assign IN_SERVICE_LO = isr_q.lo;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_call_length: assert property ($rose(CALL_ACTIVE) |-> CALL_ACTIVE [*4] ##1 !CALL_ACTIVE)
    else $error("call sequence length wrong");
  a_call_start: assert property (entry |=> CALL_ACTIVE && CALL_VECTOR == vec_of($past(sel_q)))
    else $error("call not started with the right vector");
  a_call_boundary: assert property ($rose(CALL_ACTIVE) |-> $past(INSN_END) && $past(IRQ_REQ))
    else $error("call started off an instruction boundary");
  a_global_off: assert property (!ea_q |=> !IRQ_REQ)
    else $error("request raised while globally disabled");
  a_disabled_quiet: assert property ($rose(IRQ_REQ) |-> $past(cand) != '0)
    else $error("request without an enabled pending flag");
  a_event_sticky: assert property (EVENT[1] |=> pend_q[1])
    else $error("event did not set its pending flag");
  a_soft_set: assert property (wr_go && ADDRESS == `REG_PEND_SET && wd[4] |=> pend_q[4])
    else $error("software set of pending flag lost");
  a_level_follow: assert property (!cfg_q.edge_sel[0] |=> pend_q[0] == $past(ext_act[0]))
    else $error("level flag does not follow input");
  a_edge_autoclr: assert property (entry && sel_q == 4'h0 && cfg_q.edge_sel[0] && !ext_edge[0] && !wr_go
    |=> !pend_q[0])
    else $error("edge flag not cleared on vectoring");
  a_high_locked: assert property (IN_SERVICE_HI && !RETURN_FROM_INTERRUPT_END |=> !IRQ_REQ)
    else $error("request raised during high level service");
  a_high_first: assert property (hi_any && !isr_d.hi && st_d == ST_IDLE |=> IRQ_REQ && sel_lvl_q && sel_q == $past(hi_idx))
    else $error("high level not served first");

  c_entry: cover property ($rose(CALL_ACTIVE));
  c_preempt: cover property (IN_SERVICE_LO && $rose(IN_SERVICE_HI));
  c_reenter: cover property (RETURN_FROM_INTERRUPT_END ##[1:20] $rose(CALL_ACTIVE));
endmodule // irq_handler
`default_nettype wire

// ### verilog/irq_pick.sv
// fixed order picker: the lowest index among the requests wins
// assumes nothing beyond a combinational context
`timescale 1ns/1ps
`default_nettype none
module irq_pick #(
  parameter int N = 13,
  parameter int W = 4
) (
  // requests
  input wire logic [N-1:0] req,
  // result
  output logic any,
  output logic [W-1:0] idx
);
  always_comb begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = W'(i);
      end
    end
  end
endmodule // irq_pick
`default_nettype wire
